// ### verilog/cmp_blank_regs.svh
/*
  Register offsets, writable masks, reset values and divider codes for
  the comparator blanking and filter block. Included by its bare name.
*/
`ifndef CMP_BLANK_REGS_SVH
`define CMP_BLANK_REGS_SVH

// ----------------------------------------------------------------------
// Offsets (byte addresses)
// ----------------------------------------------------------------------
`define MASK_SRC_OFF 4'h0
`define MASK_GATE_OFF 4'h4
`define FILTER_CTL_OFF 4'h8
`define STATUS_OFF 4'hC

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define MASK_SRC_RST 16'h0000
`define MASK_GATE_RST 16'h0000
`define FILTER_CTL_RST 16'h0000
`define MASK_SRC_WMASK 16'h0FFF
`define MASK_GATE_WMASK 16'hBFFF
`define FILTER_CTL_WMASK 16'h007F

// ----------------------------------------------------------------------
// Source codes
// ----------------------------------------------------------------------
`define SRC_FAULT4 4'hF
`define SRC_FAULT2 4'hE
`define SRC_TRIG19 4'hD
`define SRC_TRIG18 4'hC
`define SRC_PWM_THREE_HIGH 4'h5
`define SRC_PWM_THREE_LOW 4'h4
`define SRC_PWM_TWO_HIGH 4'h3
`define SRC_PWM_TWO_LOW 4'h2
`define SRC_PWM_ONE_HIGH 4'h1
`define SRC_PWM_ONE_LOW 4'h0

`define CLK_PERIPH 3'h0
`define CLK_OSC 3'h1
`define CLK_SYNC 3'h2
`define CLK_RSVD 3'h3

// Divider ratio minus one, per code 0..7
`define DIV_1 6'h00
`define DIV_2 6'h01
`define DIV_4 6'h03
`define DIV_8 6'h07
`define DIV_16 6'h0F
`define DIV_32 6'h1F
`define DIV_64 6'h3F
`define FILTER_DEPTH 3

`endif

// ### verilog/cmp_blank_pkg.sv
/*
  Types for the comparator blanking and filter block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package cmp_blank_pkg;
  typedef struct packed {
    logic [3:0] c_sel;
    logic [3:0] b_sel;
    logic [3:0] a_sel;
  } mask_src_t;

  typedef struct packed {
    logic blank_level_select;
    logic or_c_true_en;
    logic or_c_inv_en;
    logic or_b_true_en;
    logic or_b_inv_en;
    logic or_a_true_en;
    logic or_a_inv_en;
    logic or_and_inv_en;
    logic or_and_true_en;
    logic and_in_c_true_en;
    logic and_in_c_inv_en;
    logic and_in_b_true_en;
    logic and_in_b_inv_en;
    logic and_in_a_true_en;
    logic and_in_a_inv_en;
  } mask_gate_t;

  typedef struct packed {
    logic [2:0] filter_clock_source_sel;
    logic filter_enable_bit;
    logic [2:0] filter_clock_divider_sel;
  } filter_ctl_t;

  typedef struct packed {
    logic fault_input_four;
    logic fault_input_two;
    logic trigger_gen_out_nineteen;
    logic trigger_gen_out_eighteen;
    logic pwm_three_high;
    logic pwm_three_low;
    logic pwm_two_high;
    logic pwm_two_low;
    logic pwm_one_high;
    logic pwm_one_low;
  } blank_src_t;

  typedef struct packed {
    logic timer_five_clock;
    logic timer_four_clock;
    logic timer_three_clock;
    logic timer_two_clock;
    logic pwm_sync_output;
    logic osc_clock;
  } filter_clk_src_t;
endpackage
`default_nettype wire

// ### verilog/mask_source_mux.sv
/*
  One mask source selector: picks a blanking source by a 4-bit code.
  Assumes sources already synchronised to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cmp_blank_regs.svh"

module mask_source_mux
  import cmp_blank_pkg::*;
(
  input wire blank_src_t src_i, // Synchronised blanking sources
  input wire logic [3:0] sel_i, // Source code
  output logic mask_o           // Selected mask input
);

  always_comb
  begin
    unique case (sel_i)
      `SRC_FAULT4: mask_o = src_i.fault_input_four;
      `SRC_FAULT2: mask_o = src_i.fault_input_two;
      `SRC_TRIG19: mask_o = src_i.trigger_gen_out_nineteen;
      `SRC_TRIG18: mask_o = src_i.trigger_gen_out_eighteen;
      `SRC_PWM_THREE_HIGH: mask_o = src_i.pwm_three_high;
      `SRC_PWM_THREE_LOW: mask_o = src_i.pwm_three_low;
      `SRC_PWM_TWO_HIGH: mask_o = src_i.pwm_two_high;
      `SRC_PWM_TWO_LOW: mask_o = src_i.pwm_two_low;
      `SRC_PWM_ONE_HIGH: mask_o = src_i.pwm_one_high;
      `SRC_PWM_ONE_LOW: mask_o = src_i.pwm_one_low;
      // Reserved codes give no mask
      default: mask_o = 1'b0;
    endcase
  end

endmodule // mask_source_mux
`default_nettype wire

// ### verilog/comparator_blanking_filter.sv
/*
  Comparator blanking and digital filter with a classic Wishbone slave.
  Assumes comparator, blanking sources and filter clock sources are
  asynchronous pins; the bus runs on clk_i.
*/
// Behaviour
// R1 - Mask C source picked by 4-bit code: faults, triggers, PWM outputs.
// R2 - Mask B uses same code set; 0110 to 1011 reserved.
// R3 - Mask A uses same code set; 1100 and 1101 pick triggers.
// R4 - AND term takes true and/or inverted mask A per enables.
// R5 - AND term takes true and/or inverted mask B per enables.
// R6 - Filter sample clock chosen by 3-bit code; 011 reserved.
// R7 - Filter clock divided 64, 32, 16, 8 for codes 111 to 100.
// R8 - OR term of masks and AND term blanks the chosen active level.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_blank_regs.svh"

module comparator_blanking_filter
  import cmp_blank_pkg::*;
(
  input wire logic clk_i,               // 125 MHz clock
  input wire logic rst_i,               // Synchronous reset, high
  input wire logic ce_i,                // Clock enable
  input wire logic wb_cyc_i,            // Wishbone cycle
  input wire logic wb_stb_i,            // Wishbone strobe
  input wire logic wb_we_i,             // Wishbone write
  input wire logic [3:0] wb_adr_i,      // Wishbone byte address
  input wire logic [3:0] wb_sel_i,      // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,     // Wishbone write data
  output logic [31:0] wb_dat_o,         // Wishbone read data
  output logic wb_ack_o,                // Wishbone acknowledge
  input wire logic cmp_raw_i,           // Raw comparator output pin
  input wire blank_src_t blank_src_i,   // Blanking source pins
  input wire filter_clk_src_t fclk_i,   // Filter clock source pins
  output logic cmp_out_o                // Blanked, filtered output
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int SW = $bits(blank_src_t) + $bits(filter_clk_src_t) + 1;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  blank_src_t src_s;
  filter_clk_src_t fclk_s;
  logic cmp_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else if (ce_i)
    begin
      sync1 <= {blank_src_i, fclk_i, cmp_raw_i};
      sync2 <= sync1;
    end
  end

  assign {src_s, fclk_s, cmp_s} = sync2;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] mask_src_q;
  logic [15:0] mask_gate_q;
  logic [15:0] filter_ctl_q;
  mask_src_t msrc;
  mask_gate_t mgate;
  filter_ctl_t fctl;
  logic bus_req;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic blank;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i[15:0];
  assign msrc = mask_src_t'(mask_src_q[11:0]);
  assign mgate = mask_gate_t'({mask_gate_q[15], mask_gate_q[13:0]});
  assign fctl = filter_ctl_t'(filter_ctl_q[6:0]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_src_q <= `MASK_SRC_RST;
      mask_gate_q <= `MASK_GATE_RST;
      filter_ctl_q <= `FILTER_CTL_RST;
    end
    else if (ce_i && bus_req && wb_we_i)
    begin
      unique case (wb_adr_i)
        `MASK_SRC_OFF:
          mask_src_q <= (mask_src_q & ~(wmask & `MASK_SRC_WMASK))
                        | (wdata & wmask & `MASK_SRC_WMASK);
        `MASK_GATE_OFF:
          mask_gate_q <= (mask_gate_q & ~(wmask & `MASK_GATE_WMASK))
                         | (wdata & wmask & `MASK_GATE_WMASK);
        `FILTER_CTL_OFF:
          filter_ctl_q <= (filter_ctl_q & ~(wmask & `FILTER_CTL_WMASK))
                          | (wdata & wmask & `FILTER_CTL_WMASK);
        default:
        begin
        end
      endcase
    end
  end

  // One-cycle ack, single wait-free answer; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          `MASK_SRC_OFF: wb_dat_o <= {16'h0000, mask_src_q};
          `MASK_GATE_OFF: wb_dat_o <= {16'h0000, mask_gate_q};
          `FILTER_CTL_OFF: wb_dat_o <= {16'h0000, filter_ctl_q};
          `STATUS_OFF: wb_dat_o <= {29'h00000000, blank, cmp_s, cmp_out_o};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mask source selection
  // ----------------------------------------------------------------------
  logic mask_input_a;
  logic mask_input_b;
  logic mask_input_c;

  // R1 mask C selector
  mask_source_mux mux_c (
    .src_i(src_s),
    .sel_i(msrc.c_sel),
    .mask_o(mask_input_c)
  );

  // R2 mask B selector
  mask_source_mux mux_b (
    .src_i(src_s),
    .sel_i(msrc.b_sel),
    .mask_o(mask_input_b)
  );

  // R3 mask A selector
  mask_source_mux mux_a (
    .src_i(src_s),
    .sel_i(msrc.a_sel),
    .mask_o(mask_input_a)
  );

  // ----------------------------------------------------------------------
  // Gating network
  // ----------------------------------------------------------------------
  logic and_term_out;
  logic and_any;
  logic cmp_blanked;

  // Empty AND gate gives 0 so an unconfigured network never blanks
  assign and_any = mgate.and_in_a_true_en | mgate.and_in_a_inv_en
                 | mgate.and_in_b_true_en | mgate.and_in_b_inv_en
                 | mgate.and_in_c_true_en | mgate.and_in_c_inv_en;

  // R4 R5 AND term copies
  assign and_term_out = and_any
    & (~mgate.and_in_a_true_en | mask_input_a)
    & (~mgate.and_in_a_inv_en | ~mask_input_a)
    & (~mgate.and_in_b_true_en | mask_input_b)
    & (~mgate.and_in_b_inv_en | ~mask_input_b)
    & (~mgate.and_in_c_true_en | mask_input_c)
    & (~mgate.and_in_c_inv_en | ~mask_input_c);

  // R8 OR term
  assign blank = (mgate.or_a_true_en & mask_input_a)
               | (mgate.or_a_inv_en & ~mask_input_a)
               | (mgate.or_b_true_en & mask_input_b)
               | (mgate.or_b_inv_en & ~mask_input_b)
               | (mgate.or_c_true_en & mask_input_c)
               | (mgate.or_c_inv_en & ~mask_input_c)
               | (mgate.or_and_true_en & and_term_out)
               | (mgate.or_and_inv_en & ~and_term_out);

  // R8 level blanking: select 1 suppresses a 0, select 0 suppresses a 1
  assign cmp_blanked = blank ? mgate.blank_level_select : cmp_s;

  // ----------------------------------------------------------------------
  // Filter clock select and divider
  // ----------------------------------------------------------------------
  logic sel_clk;
  logic sel_clk_d;
  logic sel_tick;
  logic [5:0] div_limit;
  logic [5:0] div_cnt;
  logic sample_tick;

  // R6 clock source
  always_comb
  begin
    unique case (fctl.filter_clock_source_sel)
      3'h7: sel_clk = fclk_s.timer_five_clock;
      3'h6: sel_clk = fclk_s.timer_four_clock;
      3'h5: sel_clk = fclk_s.timer_three_clock;
      3'h4: sel_clk = fclk_s.timer_two_clock;
      `CLK_SYNC: sel_clk = fclk_s.pwm_sync_output;
      `CLK_OSC: sel_clk = fclk_s.osc_clock;
      `CLK_PERIPH: sel_clk = 1'b1;
      `CLK_RSVD: sel_clk = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sel_clk_d <= 1'b0;
    else if (ce_i)
      sel_clk_d <= sel_clk;
  end

  // Peripheral clock ticks every cycle; others on rising edges
  assign sel_tick = (fctl.filter_clock_source_sel == `CLK_PERIPH)
                    || (sel_clk && !sel_clk_d);

  // R7 divider ratio
  always_comb
  begin
    unique case (fctl.filter_clock_divider_sel)
      3'h7: div_limit = `DIV_64;
      3'h6: div_limit = `DIV_32;
      3'h5: div_limit = `DIV_16;
      3'h4: div_limit = `DIV_8;
      3'h3: div_limit = `DIV_4;
      3'h2: div_limit = `DIV_2;
      3'h1: div_limit = `DIV_2;
      3'h0: div_limit = `DIV_1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_cnt <= 6'h00;
    else if (ce_i && sel_tick)
      div_cnt <= (div_cnt >= div_limit) ? 6'h00 : div_cnt + 6'h01;
  end

  assign sample_tick = sel_tick && (div_cnt >= div_limit);

  // ----------------------------------------------------------------------
  // Digital filter: output follows after FILTER_DEPTH equal samples
  // ----------------------------------------------------------------------
  logic [`FILTER_DEPTH-1:0] hist;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hist <= '0;
    else if (ce_i && sample_tick)
      hist <= {hist[`FILTER_DEPTH-2:0], cmp_blanked};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmp_out_o <= 1'b0;
    else if (ce_i)
    begin
      if (!fctl.filter_enable_bit)
        cmp_out_o <= cmp_blanked;
      else if (&hist)
        cmp_out_o <= 1'b1;
      else if (~|hist)
        cmp_out_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence wb_read_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && ce_i;
  endsequence

  mask_c_route_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (msrc.c_sel == `SRC_FAULT4) |-> mask_input_c == src_s.fault_input_four)
    else $error("mask C not routed from fault four");

  mask_b_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (msrc.b_sel inside {[4'h6:4'hB]}) |-> !mask_input_b)
    else $error("reserved mask B code not zero");

  mask_a_trig_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    (msrc.a_sel == `SRC_TRIG18)
      |-> mask_input_a == src_s.trigger_gen_out_eighteen)
    else $error("mask A not routed from trigger eighteen");

  and_a_true_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (mgate.and_in_a_true_en && !mask_input_a) |-> !and_term_out)
    else $error("AND term ignores low mask A");

  and_b_inv_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (mgate.and_in_b_inv_en && mask_input_b) |-> !and_term_out)
    else $error("AND term ignores inverted mask B");

  periph_tick_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (fctl.filter_clock_source_sel == `CLK_PERIPH) |-> sel_tick)
    else $error("peripheral clock not ticking");

  div_range_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (fctl.filter_clock_divider_sel == 3'h7) |-> div_limit == 6'h3F)
    else $error("divide by 64 limit wrong");

  blank_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (ce_i && blank && !fctl.filter_enable_bit && $stable(filter_ctl_q))
      |=> cmp_out_o == $past(mgate.blank_level_select))
    else $error("blanked output not at inactive level");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_read_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle");

endmodule // comparator_blanking_filter
`default_nettype wire

// ### bench/far_side_model.sv
/*
  Far side model: PWM, fault and trigger outputs and filter clock pins.
  Assumes the bench sets the wanted source levels between its checks.
*/
`timescale 1ns/10ps
`default_nettype none

module far_side_model
  import cmp_blank_pkg::*;
(
  input wire logic clk_i,         // Bench clock
  input wire blank_src_t pat_i,   // Wanted source levels
  output var blank_src_t src_o,   // Blanking source pins
  output var filter_clk_src_t fclk_o // Filter clock source pins
);
  logic [3:0] cnt = 4'h0;

  always_ff @(posedge clk_i)
  begin
    cnt <= cnt + 4'h1;
    src_o <= pat_i;
  end

  // Timer two runs at one eighth of the bus clock
  assign fclk_o = {cnt[3], cnt[3], cnt[2], cnt[2], cnt[1], cnt[1]};
endmodule // far_side_model

`default_nettype wire

// ### bench/test_comparator_blanking_filter.sv
/*
  Self-checking bench: Wishbone register accesses, mask routing,
  gating, blanking level and filter timing.
  Assumes the design package and register header are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cmp_blank_regs.svh"
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end \
  end

module test_comparator_blanking_filter
  import cmp_blank_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cmp_raw_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, cmp_out_o;
  blank_src_t pat = '0, blank_src_i;
  filter_clk_src_t fclk_i;
  int bad_count = 0, checks = 0;
  logic [6:0] fcfg [10] = '{7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h48, 7'h0B,
                            7'h0A, 7'h28, 7'h18, 7'h68};
  int ratio [10] = '{8, 16, 32, 64, 8, 4, 2, 4, 4, 16};
  logic [15:0] gcfg [5] = '{16'h0042, 16'h0041, 16'h0048, 16'h0044,
                            16'h0082};

  comparator_blanking_filter comparator_blanking_filter_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp_raw_i(cmp_raw_i),
    .blank_src_i(blank_src_i), .fclk_i(fclk_i), .cmp_out_o(cmp_out_o));

  far_side_model far_side_model_inst (
    .clk_i(clk_i), .pat_i(pat), .src_o(blank_src_i), .fclk_o(fclk_i));

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------------
  // Bus access and closing
  // ------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [15:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20)
      bad_count++;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Generous bound on the whole sequence, a hang must not pass
  initial
  begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    int idx, n;
    logic a, b, t, rv;
    logic [15:0] g;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      xfer(1'b0, 4'(4 * k), 16'h0000, q);
      `CHK(q, 32'h0)
      wr(4'(4 * k), 16'hFFFF);
      xfer(1'b0, 4'(4 * k), 16'h0000, q);
      `CHK(q, {16'h0, k == 0 ? `MASK_SRC_WMASK : k == 1 ?
               `MASK_GATE_WMASK : `FILTER_CTL_WMASK})
    end
    wr(`FILTER_CTL_OFF, 16'h0000);
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 16; c++)
      begin
        idx = c >= 12 ? c - 6 : c;
        wr(`MASK_SRC_OFF, 16'(c) << (4 * m));
        wr(`MASK_GATE_OFF, 16'h0200 << (2 * m));
        for (int p = 0; p < 2; p++)
        begin
          pat <= p ? ~(10'h001 << idx) : (10'h001 << idx);
          repeat (6) @(posedge clk_i);
          xfer(1'b0, `STATUS_OFF, 16'h0000, q);
          `CHK(q[2], (c < 6 || c >= 12) && p == 0)
        end
      end
    // Mask A from lowest PWM output, mask B from the next one
    wr(`MASK_SRC_OFF, 16'h0010);
    for (int k = 0; k < 5; k++)
    begin
      g = gcfg[k];
      wr(`MASK_GATE_OFF, g);
      for (int v = 0; v < 4; v++)
      begin
        a = v[0];
        b = v[1];
        pat <= {8'h00, b, a};
        t = (g[1] ? a : 1'b1) & (g[0] ? ~a : 1'b1) &
            (g[3] ? b : 1'b1) & (g[2] ? ~b : 1'b1);
        repeat (6) @(posedge clk_i);
        xfer(1'b0, `STATUS_OFF, 16'h0000, q);
        `CHK(q[2], (g[6] & t) | (g[7] & ~t))
      end
    end
    wr(`MASK_SRC_OFF, 16'h0000);
    for (int v = 0; v < 8; v++)
    begin
      wr(`MASK_GATE_OFF, {v[2], 15'h0200});
      pat <= {9'h000, v[1]};
      cmp_raw_i <= v[0];
      repeat (8) @(posedge clk_i);
      `CHK(cmp_out_o, v[1] ? v[2] : v[0])
    end
    wr(`MASK_GATE_OFF, 16'h0000);
    for (int k = 0; k < 10; k++)
    begin
      wr(`FILTER_CTL_OFF, {9'h000, fcfg[k]});
      repeat (300) @(posedge clk_i);
      rv = ~cmp_raw_i;
      cmp_raw_i <= rv;
      n = 0;
      while (cmp_out_o !== rv && n < 3 * ratio[k] + 20)
      begin
        @(posedge clk_i);
        n++;
      end
      `CHK(cmp_out_o, rv)
      `CHK(n >= 2 * ratio[k] - 4, 1'b1)
    end
    // Reserved filter clock never samples, output must stay put
    wr(`FILTER_CTL_OFF, 16'h0038);
    cmp_raw_i <= ~rv;
    repeat (200) @(posedge clk_i);
    `CHK(cmp_out_o, rv)
    // Filter off, then the clock enable must freeze the output path
    wr(`FILTER_CTL_OFF, 16'h0000);
    repeat (6) @(posedge clk_i);
    `CHK(cmp_out_o, ~rv)
    ce_i <= 1'b0;
    cmp_raw_i <= rv;
    repeat (10) @(posedge clk_i);
    `CHK(cmp_out_o, ~rv)
    ce_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK(cmp_out_o, rv)
    // Second reset in mid-run restores defaults
    wr(`MASK_GATE_OFF, 16'h8000);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(cmp_out_o, 1'b0)
    xfer(1'b0, `MASK_GATE_OFF, 16'h0000, q);
    `CHK(q, 32'h0)
    conclude();
  end
endmodule // test_comparator_blanking_filter

`default_nettype wire
